/* logic/nvs_spi_cmd.sv */
// Serial command engine of a 128K x 8 nonvolatile SRAM.
// Assumes SPI pins arrive asynchronously and are oversampled by CLOCK;
// the array sits outside behind a byte read/write port.
`timescale 1ns/100ps
// Functional notes
// R1: Read: opcode, three address bytes, top bit.
// R2: Read data shifted out MSB first, falling.
// R3: Input after last read address bit ignored.
// R4: Read bursts increment, wrap top to zero.
// R5: Host keeps read slow; single byte ends.
// R6: Fast read adds one dummy byte.
// R7: Host may clock fast read faster.
// R8: Fast read increments, wraps, ends anytime.
// R9: Host sets write latch before writing.
// R10: Write: opcode, address, then data bytes.
// R11: Write bursts go to successive wrapping addresses.
// R12: Write latch cleared when write completes.
// R13: Protected addresses skipped, increment continues.
// R14: Opcode 3C starts software save.
// R15: Save runs even without prior writes.
// R16: Opcode 60 restore, needs write latch.
// R17: Opcode 59 enables automatic save.
// R18: Opcode 19 disables automatic save.
// R19: Automatic save enabled after reset.
// R20: Autosave commands busy for processing time.
// R21: Special commands need latch, cleared on deselect.
// R22: Latch clear ignores command until deselect.
// R23: Busy flag raised during save or restore.
// R24: No array access while busy.
// R25: Protect bits select none, quarter, half, all.
// R26: Bits sampled on rising serial clock.
// R27: Read, fast read, write opcodes configurable.
module nvs_spi_cmd
    import nvs_pkg::*;
#(
    parameter logic [7:0] OP_READ = 8'h03,
    parameter logic [7:0] OP_FAST_READ = 8'h0B,
    parameter logic [7:0] OP_WRITE = 8'h02,
    parameter logic [7:0] OP_SET_LATCH = 8'h06
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // SPI pins
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    output logic SO,
    output logic SO_OE_N,
    // Protection and status
    input wire logic BLOCK_PROTECT_LO,
    input wire logic BLOCK_PROTECT_HI,
    input wire logic NV_DONE,
    output logic WRITE_LATCH,
    output logic AUTOSAVE_EN,
    output logic BUSY,
    output logic SAVE_REQ,
    output logic RESTORE_REQ,
    // Array port
    output logic [16:0] MEM_ADDR,
    output logic MEM_RD,
    input wire logic [7:0] MEM_RDATA,
    output logic MEM_WR,
    output logic [16:0] MEM_WADDR,
    output logic [7:0] MEM_WDATA,
    input wire logic MEM_WREADY
);
    initial
    begin
        if (OP_READ == OP_WRITE || OP_READ == OP_FAST_READ)
            $error("nvs_spi_cmd opcodes must differ");
        if (SEQ_PROCESS_CYC < 1 || SEQ_PROCESS_CYC > 15)
            $error("nvs_spi_cmd sequence time exceeds its counter");
    end
    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] cs_s_q;
    logic [1:0] sck_s_q;
    logic [1:0] si_s_q;
    logic cs_d1_q;
    logic sck_d1_q;
    logic cs_n;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            cs_s_q <= 2'h3;
            sck_s_q <= 2'h0;
            si_s_q <= 2'h0;
            cs_d1_q <= 1'b1;
            sck_d1_q <= 1'b0;
        end
        else
        begin
            cs_s_q <= {cs_s_q[0], CS_N};
            sck_s_q <= {sck_s_q[0], SCK};
            si_s_q <= {si_s_q[0], SI};
            cs_d1_q <= cs_s_q[1];
            sck_d1_q <= sck_s_q[1];
        end
    end
    assign cs_n = cs_s_q[1];
    assign sck_rise = !cs_n && sck_s_q[1] && !sck_d1_q; // R26
    assign sck_fall = !cs_n && !sck_s_q[1] && sck_d1_q;
    assign cs_rise = cs_n && !cs_d1_q;
    // ----------------------------------------------------------------
    // Bit and byte assembly
    // ----------------------------------------------------------------
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic [7:0] byte_in;
    logic byte_done;
    assign byte_in = {sh_q[6:0], si_s_q[1]};
    assign byte_done = sck_rise && bit_q == 3'h7;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            bit_q <= 3'h0;
            sh_q <= 8'h00;
        end
        else if (cs_n)
            bit_q <= 3'h0;
        else if (sck_rise)
        begin
            bit_q <= bit_q + 3'h1;
            sh_q <= byte_in;
        end
    end
    // ----------------------------------------------------------------
    // Protection decode
    // ----------------------------------------------------------------
    function automatic logic prot(input logic [16:0] a,
        input logic hi, input logic lo);
        case ({hi, lo}) // R25
            2'h0: prot = 1'b0;
            2'h1: prot = a >= QUARTER_BASE;
            2'h2: prot = a >= HALF_BASE;
            default: prot = 1'b1;
        endcase
    endfunction
    // ----------------------------------------------------------------
    // Command state machine
    // ----------------------------------------------------------------
    nvs_state_t st_q;
    logic [1:0] acnt_q;
    logic [16:0] addr_q;
    logic is_read_q;
    logic is_fast_q;
    logic [7:0] pend_q;
    logic wrote_q;
    logic fifo_ready;
    logic busy_now;
    assign busy_now = BUSY;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_q <= ST_IDLE;
            acnt_q <= 2'h0;
            addr_q <= ADDR_ZERO;
            is_read_q <= 1'b0;
            is_fast_q <= 1'b0;
            pend_q <= 8'h00;
            wrote_q <= 1'b0;
        end
        else if (cs_n)
        begin
            st_q <= ST_IDLE; // R22
            acnt_q <= 2'h0;
        end
        else if (byte_done)
        begin
            case (st_q)
                ST_IDLE, ST_OPCODE:
                begin
                    pend_q <= byte_in;
                    wrote_q <= 1'b0;
                    is_fast_q <= byte_in == OP_FAST_READ;
                    is_read_q <= byte_in == OP_READ ||
                        byte_in == OP_FAST_READ;
                    if (busy_now)
                        st_q <= ST_SKIP; // R24
                    else if (byte_in == OP_READ ||
                        byte_in == OP_FAST_READ) // R27
                        st_q <= ST_ADDR;
                    else if (byte_in == OP_WRITE && WRITE_LATCH)
                        st_q <= ST_ADDR; // R10
                    else
                        st_q <= ST_SKIP; // R22
                end
                ST_ADDR:
                begin
                    acnt_q <= acnt_q + 2'h1;
                    case (acnt_q)
                        2'h0: addr_q[16] <= byte_in[0]; // R1
                        2'h1: addr_q[15:8] <= byte_in;
                        default: addr_q[7:0] <= byte_in;
                    endcase
                    if (acnt_q == 2'h2)
                        st_q <= !is_read_q ? ST_WRITE :
                            (is_fast_q ? ST_DUMMY : ST_READ); // R6
                end
                ST_DUMMY:
                    st_q <= ST_READ;
                // Advance at last rise, array settles before next fall
                ST_READ:
                    addr_q <= addr_q == ADDR_TOP ? ADDR_ZERO
                        : addr_q + 17'h1; // R3 R4 R8
                ST_WRITE:
                begin
                    wrote_q <= 1'b1;
                    addr_q <= addr_q == ADDR_TOP ? ADDR_ZERO
                        : addr_q + 17'h1; // R11
                end
                ST_SKIP:
                    st_q <= ST_SKIP;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // Read data path: fetch byte, shift MSB first on falling edge
    // ----------------------------------------------------------------
    logic [7:0] out_q;
    logic so_q;
    logic so_oe_n_q;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            out_q <= 8'h00;
            so_q <= 1'b0;
            so_oe_n_q <= 1'b1;
        end
        else if (st_q != ST_READ || cs_n)
            so_oe_n_q <= 1'b1;
        else if (sck_fall)
        begin
            so_oe_n_q <= 1'b0;
            if (bit_q == 3'h0)
            begin
                so_q <= MEM_RDATA[7]; // R2
                out_q <= {MEM_RDATA[6:0], 1'b0};
            end
            else
            begin
                so_q <= out_q[7];
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end
    assign SO = so_q;
    assign SO_OE_N = so_oe_n_q;
    // Array read address tracks the burst pointer
    logic [16:0] mem_addr_q;
    logic mem_rd_q;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            mem_addr_q <= ADDR_ZERO;
            mem_rd_q <= 1'b0;
        end
        else
        begin
            mem_addr_q <= addr_q;
            mem_rd_q <= st_q == ST_READ && !cs_n;
        end
    end
    assign MEM_ADDR = mem_addr_q;
    assign MEM_RD = mem_rd_q;
    // ----------------------------------------------------------------
    // Write data path through the FIFO, protected bytes dropped
    // ----------------------------------------------------------------
    logic push;
    logic f_valid;
    logic [24:0] f_data;
    assign push = st_q == ST_WRITE && byte_done &&
        !prot(addr_q, BLOCK_PROTECT_HI, BLOCK_PROTECT_LO); // R13
    nvs_fifo #(.WIDTH(25), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLOCK),
        .nrst(NRST),
        .in_valid(push),
        .in_ready(fifo_ready),
        .in_data({addr_q, byte_in}),
        .out_valid(f_valid),
        .out_ready(MEM_WREADY && !MEM_WR),
        .out_data(f_data)
    );
    logic mem_wr_q;
    logic [24:0] wr_hold_q;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            mem_wr_q <= 1'b0;
            wr_hold_q <= '0;
        end
        else
        begin
            mem_wr_q <= f_valid && MEM_WREADY && !mem_wr_q;
            if (f_valid && MEM_WREADY && !mem_wr_q)
                wr_hold_q <= f_data;
        end
    end
    assign MEM_WR = mem_wr_q;
    assign MEM_WADDR = wr_hold_q[24:8];
    assign MEM_WDATA = wr_hold_q[7:0];
    // ----------------------------------------------------------------
    // Write latch, autosave setting, special commands on deselect
    // ----------------------------------------------------------------
    logic latch_q;
    logic auto_q;
    logic save_q;
    logic restore_q;
    logic nv_busy_q;
    logic [3:0] seq_cnt_q;
    logic special;
    assign special = pend_q == OP_SAVE || pend_q == OP_RESTORE ||
        pend_q == OP_AUTOSAVE_ON || pend_q == OP_AUTOSAVE_OFF;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
        begin
            latch_q <= WRITE_LATCH_RESET;
            auto_q <= AUTOSAVE_RESET; // R19
            save_q <= 1'b0;
            restore_q <= 1'b0;
            nv_busy_q <= 1'b0;
            seq_cnt_q <= 4'h0;
        end
        else
        begin
            save_q <= 1'b0;
            restore_q <= 1'b0;
            if (seq_cnt_q != 4'h0)
                seq_cnt_q <= seq_cnt_q - 4'h1;
            if (NV_DONE)
                nv_busy_q <= 1'b0;
            if (cs_rise && st_q == ST_SKIP && !BUSY)
            begin
                if (pend_q == OP_SET_LATCH)
                    latch_q <= 1'b1;
                else if (special && latch_q) // R21
                begin
                    latch_q <= 1'b0;
                    if (pend_q == OP_SAVE)
                    begin
                        save_q <= 1'b1; // R14 R15
                        nv_busy_q <= 1'b1;
                    end
                    else if (pend_q == OP_RESTORE)
                    begin
                        restore_q <= 1'b1; // R16
                        nv_busy_q <= 1'b1;
                    end
                    else
                    begin
                        auto_q <= pend_q == OP_AUTOSAVE_ON; // R17 R18
                        seq_cnt_q <= 4'(SEQ_PROCESS_CYC); // R20
                    end
                end
            end
            else if (cs_rise && st_q == ST_WRITE && wrote_q)
                latch_q <= 1'b0; // R12
        end
    end
    assign WRITE_LATCH = latch_q;
    assign AUTOSAVE_EN = auto_q;
    assign SAVE_REQ = save_q;
    assign RESTORE_REQ = restore_q;
    // Busy covers nonvolatile cycles and sequence processing
    logic busy_q;
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            busy_q <= 1'b0;
        else
            busy_q <= nv_busy_q || seq_cnt_q != 4'h0 || save_q ||
                restore_q || !fifo_ready; // R23
    end
    assign BUSY = busy_q;
endmodule

/* logic/nvs_pkg.sv */
// Package for the serial nvSRAM command block: opcodes, sizes, timing.
// Assumes a single 10 MHz system clock in every user of the package.
package nvs_pkg;
    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam logic [16:0] ADDR_TOP = 17'h1FFFF;
    localparam logic [16:0] ADDR_ZERO = 17'h00000;
    localparam logic [16:0] QUARTER_BASE = 17'h18000;
    localparam logic [16:0] HALF_BASE = 17'h10000;
    // ----------------------------------------------------------------
    // Special opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_SAVE = 8'h3C;
    localparam logic [7:0] OP_RESTORE = 8'h60;
    localparam logic [7:0] OP_AUTOSAVE_ON = 8'h59;
    localparam logic [7:0] OP_AUTOSAVE_OFF = 8'h19;
    // ----------------------------------------------------------------
    // Timing: sequence processing time in ns and in cycles
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SEQ_PROCESS_NS = 500;
    localparam int SEQ_PROCESS_CYC =
        (SEQ_PROCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic AUTOSAVE_RESET = 1'b1;
    localparam logic WRITE_LATCH_RESET = 1'b0;
    localparam int FIFO_DEPTH = 16;
    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_WRITE,
        ST_SKIP
    } nvs_state_t;
endpackage

/* logic/nvs_fifo.sv */
// Synchronous FIFO carrying write bytes toward the array port.
// Assumes one clock; both sides use valid/ready handshakes.
`timescale 1ns/100ps
module nvs_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("nvs_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;
    // Honest flags from pointer compare
    assign out_valid = wr_q != rd_q;
    assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q[AW-1:0]];
    // Pointers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
        end
    end
    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_q[AW-1:0]] <= in_data;
    end
endmodule

/* test/nvs_spi_cmd_assertions.sv */
// Checker of the serial nvSRAM command engine, bound to its top ports.
// Assumes the system clock CLOCK and active-low reset NRST.
`timescale 1ns/100ps
module nvs_spi_cmd_assertions (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Watched pins
    input wire logic CS_N,
    input wire logic SO_OE_N,
    input wire logic BLOCK_PROTECT_LO,
    input wire logic BLOCK_PROTECT_HI,
    input wire logic AUTOSAVE_EN,
    input wire logic BUSY,
    input wire logic SAVE_REQ,
    input wire logic RESTORE_REQ,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [16:0] MEM_WADDR
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    a_autosave_reset: assert property ($rose(NRST) |-> AUTOSAVE_EN)
        else $error("automatic save off after reset");
    a_all_protected: assert property (MEM_WR |->
        !(BLOCK_PROTECT_HI && BLOCK_PROTECT_LO))
        else $error("write with whole array protected");
    a_quarter_guard: assert property (MEM_WR && !BLOCK_PROTECT_HI &&
        BLOCK_PROTECT_LO |-> MEM_WADDR < 17'h18000)
        else $error("write into protected quarter");
    a_half_guard: assert property (MEM_WR && BLOCK_PROTECT_HI &&
        !BLOCK_PROTECT_LO |-> MEM_WADDR < 17'h10000)
        else $error("write into protected half");
    a_wr_strobe: assert property (MEM_WR |=> !MEM_WR)
        else $error("write strobe longer than one cycle");
    a_save_busy: assert property (SAVE_REQ |=> BUSY ##0 !SAVE_REQ)
        else $error("save without busy");
    a_restore_busy: assert property (RESTORE_REQ |=> BUSY)
        else $error("restore without busy");
    a_req_apart: assert property (!(SAVE_REQ && RESTORE_REQ))
        else $error("save and restore together");
    a_autosave_busy: assert property ($changed(AUTOSAVE_EN)
        |-> ##[0:2] BUSY)
        else $error("automatic save change without busy");
    a_idle_quiet: assert property (CS_N [*6] |-> SO_OE_N)
        else $error("output driven while deselected");
    a_write_no_read: assert property (MEM_WR |-> !MEM_RD)
        else $error("read strobe during write");
    c_save: cover property (SAVE_REQ);
    c_quarter_wr: cover property (MEM_WR && BLOCK_PROTECT_LO);
    c_autosave_off: cover property ($fell(AUTOSAVE_EN));
endmodule
bind nvs_spi_cmd nvs_spi_cmd_assertions nvs_spi_cmd_assertions_inst (
    .CLOCK(CLOCK), .NRST(NRST), .CS_N(CS_N), .SO_OE_N(SO_OE_N),
    .BLOCK_PROTECT_LO(BLOCK_PROTECT_LO),
    .BLOCK_PROTECT_HI(BLOCK_PROTECT_HI), .AUTOSAVE_EN(AUTOSAVE_EN),
    .BUSY(BUSY), .SAVE_REQ(SAVE_REQ), .RESTORE_REQ(RESTORE_REQ),
    .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WADDR(MEM_WADDR));

/* test/nvs_host_model.sv */
// Serial host model: mode 0 frames built of whole bytes.
// Assumes the bench clock paces a slow serial clock.
`timescale 1ns/100ps
module nvs_host_model #(
    parameter int HALF = 8
) (
    // System clock
    input wire logic clk,
    // Serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so
);
    // Idle: deselected, clock low
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // Open a frame
    task automatic sel();
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (HALF) @(posedge clk);
    endtask
    // Close a frame; data line no longer holds its last bit
    task automatic desel();
        @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (4 * HALF) @(posedge clk);
    endtask
    // One byte each way, MSB first, sampled on clock rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            si <= tx[i];
            repeat (HALF) @(posedge clk);
            sck <= 1'b1;
            rx[i] = so;
            repeat (HALF) @(posedge clk);
            sck <= 1'b0;
        end
    endtask
endmodule

/* test/test_nvs_spi_cmd.sv */
// Self-checking bench of the serial nvSRAM command engine.
// Assumes a byte array behind the array port and a host model.
`timescale 1ns/100ps
module test_nvs_spi_cmd;
    import nvs_pkg::*;
    logic clock = 1'b0, nrst = 1'b0, bp_lo = 1'b0, bp_hi = 1'b0;
    logic nv_done = 1'b0, cs_n, sck, si, so, so_oe_n, mem_rd, mem_wr;
    logic write_latch, autosave_en, busy, save_req, restore_req;
    logic [16:0] mem_addr, mem_waddr;
    logic [7:0] mem_wdata, rx;
    logic [3:0] done_sr = 4'h0;
    logic [7:0] mem [0:131071];
    int n_mismatch = 0, n_compared = 0, n_wr = 0, n_sv = 0, n_rs = 0;
    always #50 clock = ~clock;
    // Array model and nonvolatile engine answer
    always @(posedge clock)
    begin
        if (mem_wr)
        begin
            mem[mem_waddr] <= mem_wdata;
            n_wr++;
        end
        n_sv += save_req;
        n_rs += restore_req;
        done_sr <= {done_sr[2:0], save_req | restore_req};
        nv_done <= done_sr[3];
    end
    nvs_spi_cmd nvs_spi_cmd_inst (.CLOCK(clock), .NRST(nrst),
        .CS_N(cs_n), .SCK(sck), .SI(si), .SO(so), .SO_OE_N(so_oe_n),
        .BLOCK_PROTECT_LO(bp_lo), .BLOCK_PROTECT_HI(bp_hi),
        .NV_DONE(nv_done), .WRITE_LATCH(write_latch),
        .AUTOSAVE_EN(autosave_en), .BUSY(busy), .SAVE_REQ(save_req),
        .RESTORE_REQ(restore_req), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
        .MEM_RDATA(mem[mem_addr]), .MEM_WR(mem_wr),
        .MEM_WADDR(mem_waddr), .MEM_WDATA(mem_wdata), .MEM_WREADY(1'b1));
    nvs_host_model nvs_host_model_inst (.clk(clock), .cs_n(cs_n),
        .sck(sck), .si(si), .so(so));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic sb(input logic [7:0] b);
        nvs_host_model_inst.xfer(b, rx);
    endtask
    task automatic cmd(input logic [7:0] op);
        nvs_host_model_inst.sel();
        sb(op);
        nvs_host_model_inst.desel();
    endtask
    // Opcode and three address bytes, spare top bits set to 7'h55
    task automatic hdr(input logic [7:0] op, input logic [16:0] a);
        nvs_host_model_inst.sel();
        sb(op);
        sb({7'h55, a[16]});
        sb(a[15:8]);
        sb(a[7:0]);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_write();
        hdr(8'h02, 17'h00010);
        sb(8'hA5);
        nvs_host_model_inst.desel();
        check(mem[17'h00010], 17'h10);
        cmd(8'h06);
        check(write_latch, 1'b1);
        hdr(8'h02, ADDR_TOP);
        sb(8'hC3);
        sb(8'h5A);
        nvs_host_model_inst.desel();
        check(mem[ADDR_TOP], 17'hC3);
        check(mem[ADDR_ZERO], 17'h5A);
        check(write_latch, 1'b0);
        $display("done write");
    endtask
    task automatic t_read();
        hdr(8'h03, ADDR_TOP);
        sb(8'hFF);
        check(rx, 17'hC3);
        sb(8'h00);
        check(rx, 17'h5A);
        nvs_host_model_inst.desel();
        hdr(8'h0B, 17'h1FFFE);
        sb(8'h00);
        sb(8'h00);
        check(rx, 17'hFE);
        sb(8'h00);
        check(rx, 17'hC3);
        sb(8'h00);
        check(rx, 17'h5A);
        nvs_host_model_inst.desel();
        $display("done read");
    endtask
    task automatic t_protect();
        logic [16:0] a;
        logic [7:0] d;
        for (int bp = 0; bp < 4; bp++)
        begin
            // Fresh addresses per level, untouched by earlier writes
            a = (bp == 0) ? 17'h08000 : (bp == 1) ? 17'h17FFF :
                (bp == 2) ? 17'h0FFFF : 17'h00100;
            d = 8'h80 + 8'(bp * 2);
            {bp_hi, bp_lo} <= 2'(bp);
            cmd(8'h06);
            hdr(8'h02, a);
            sb(d);
            sb(d + 8'h01);
            nvs_host_model_inst.desel();
            for (int k = 0; k < 2; k++)
                check(mem[a + 17'(k)], (bp == 3 || (bp == 2 && a + k >=
                    HALF_BASE) || (bp == 1 && a + k >= QUARTER_BASE)) ?
                    17'(8'(a + 17'(k))) : 17'(d + k));
        end
        {bp_hi, bp_lo} <= 2'b01;
        cmd(8'h06);
        hdr(8'h02, ADDR_TOP);
        sb(8'h33);
        sb(8'h44);
        nvs_host_model_inst.desel();
        check(mem[ADDR_TOP], 17'hC3);
        check(mem[ADDR_ZERO], 17'h44);
        check(17'(n_wr), 17'h7);
        {bp_hi, bp_lo} <= 2'b00;
        $display("done protect");
    endtask
    task automatic t_special();
        for (int k = 1; k < 3; k++)
        begin
            cmd(8'h06);
            cmd(OP_SAVE);
            check(17'(n_sv), 17'(k));
            check(write_latch, 1'b0);
        end
        cmd(OP_RESTORE);
        check(17'(n_rs), 17'h0);
        cmd(8'h06);
        cmd(OP_RESTORE);
        check(17'(n_rs), 17'h1);
        cmd(OP_AUTOSAVE_OFF);
        check(autosave_en, 1'b1);
        cmd(8'h06);
        cmd(OP_AUTOSAVE_OFF);
        check(autosave_en, 1'b0);
        cmd(8'h06);
        cmd(OP_AUTOSAVE_ON);
        check(autosave_en, 1'b1);
        $display("done special");
    endtask
    // Watchdog
    initial
    begin
        #5000000;
        n_mismatch++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        for (int i = 0; i < 131072; i++)
            mem[i] = i[7:0];
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        check(autosave_en, AUTOSAVE_RESET);
        check({busy, write_latch, so_oe_n}, 17'h1);
        t_write();
        t_read();
        t_protect();
        t_special();
        finish_test();
    end
endmodule
